// *** hw/cdea_top.sv ***
// What this block does
// - Detect select-out drop mid-sequence with address-out
// - Disconnect raises init or data interrupt
// - Drop off channel after a disconnect
// - Initial-selection disconnect sets status bit 0.1
// - Transfer disconnect sets status X'02' bit 0.5
// - Error alert raises disconnect-in to host
// - Alert when interface disable request fails
// - Program alert needs feature present and enabled
// - Service reset plus no-hold starts alert
// - Concurrent/non-concurrent modes validate commands differently
// - Mode routes interrupts to control unit or service
// - Internal and external wrap under service control
// - Service select bit 0.2 enables service functions
// - After checkout: buses enabled, host disabled
// - Checkout result readable by service command X'4B'
// - Self-test runs idle, interrupted routine is skipped
// - Power-on or service reset restarts initialization
// - Channel stop: disconnect or channel end, data interrupt
`include "cdea_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module cdea_top
	import cdea_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire logic [`CDEA_ADDR_W-1:0] reg_addr,
	input  wire logic [`CDEA_DATA_W-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [`CDEA_DATA_W-1:0] reg_rdata,
	input  wire logic                    host_address_out,
	input  wire logic                    host_select_out,
	input  wire logic                    host_command_out,
	output logic                         op_in,
	output logic                         disc_in,
	output logic                         chan_end_in,
	output logic                         ext_wrap_en,
	input  wire logic                    seq_next,
	input  wire logic                    seq_done,
	input  wire logic                    alert_feature_present,
	input  wire logic                    sp_reset_line,
	input  wire logic                    sp_nohold_line,
	input  wire logic                    cpu_intr_busy,
	output logic                         l3_init_ccu,
	output logic                         l3_data_ccu,
	output logic                         l3_init_sp,
	output logic                         l3_data_sp,
	output logic                         ioc_en,
	output logic                         sp_conn_en,
	output logic                         host_if_en,
	output logic                         svc_select
);
	cdea_state_t      st_r;
	cdea_tag_if       tg ();
	logic [15:0]      cp07_r;
	logic             alert_en_r;
	logic [7:0]       sp07_r;
	logic [4:0]       sp4c_r;
	logic             disc_r;
	logic             cstop_r;
	logic             reject_r;
	logic [6:0]       chk_cnt_r;
	logic             chk_done_r;
	logic             chk_pass_r;
	logic [7:0]       alert_cnt_r;
	logic [7:0]       dis_cnt_r;
	logic             dis_pend_r;
	logic             init_ev_r;
	logic             data_ev_r;
	logic             chan_end_r;
	logic [1:0]       diag_idx_r;
	logic [3:0]       diag_cnt_r;
	logic [`CDEA_DATA_W-1:0] rdata_r;

	logic soft_por;
	logic cp_wr_ok;
	logic disc_ev;
	logic cstop_ev;
	logic sp_alert;
	logic cp_alert;
	logic alert_go;
	logic diag_busy;

	// Wrap loops service-set tag values into the receivers
	assign tg.raw = sp4c_r[`CDEA_B_WRAP_INT] ? sp4c_r[4:2]
		: {host_command_out, host_select_out, host_address_out};
	cdea_pin_sync u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.tg       (tg.sync)
	);

	// Service reset command acts as a power-on reset of the adapter, except the SP4C wrap settings are kept and SP07 loads the written bits 6:0
	assign soft_por = reg_wr && reg_addr == `CDEA_OFF_SP07
		&& reg_wdata[`CDEA_B_SP_RESET];
	// Non-concurrent mode refuses program commands while service owns it
	assign cp_wr_ok = sp07_r[`CDEA_B_CONCUR] || !sp07_r[`CDEA_B_SVC_SEL];
	assign disc_ev = (st_r == st_init || st_r == st_xfer)
		&& tg.lvl[`CDEA_TAG_ADDR] && tg.fall[`CDEA_TAG_SEL];
	assign cstop_ev = st_r == st_xfer && tg.rise[`CDEA_TAG_CMD] && !disc_ev;
	assign sp_alert = sp_reset_line && sp_nohold_line;
	assign cp_alert = dis_pend_r && st_r != st_idle && st_r != st_alert
		&& dis_cnt_r == 8'(`CDEA_DIS_TMO_CYC - 1)
		&& alert_en_r && alert_feature_present;
	assign alert_go = chk_done_r && st_r != st_alert && (sp_alert || cp_alert);

	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por) begin
			chk_cnt_r  <= 7'h00;
			chk_done_r <= 1'b0;
			chk_pass_r <= 1'b0;
		end else if (!chk_done_r) begin
			chk_cnt_r <= chk_cnt_r + 7'h01;
			if (chk_cnt_r == 7'(`CDEA_CHK_CYC - 1)) begin
				chk_done_r <= 1'b1;
				// Passes when no receiver is stuck active
				chk_pass_r <= tg.lvl == 3'h0;
			end
		end
	end

	// Host side stays off until the program enables it
	assign ioc_en      = chk_done_r;
	assign sp_conn_en  = chk_done_r;
	assign host_if_en  = chk_done_r && cp07_r[`CDEA_B_IF_EN];
	assign svc_select  = sp07_r[`CDEA_B_SVC_SEL];
	assign ext_wrap_en = sp4c_r[`CDEA_B_WRAP_EXT];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sp07_r <= 8'h00;
			sp4c_r <= 5'h00;
		end else if (reg_wr) begin
			if (reg_addr == `CDEA_OFF_SP07)
				sp07_r <= {1'b0, reg_wdata[6:0]};
			if (reg_addr == `CDEA_OFF_SP4C)
				sp4c_r <= reg_wdata[4:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por) begin
			cp07_r     <= 16'h0000;
			alert_en_r <= 1'b0;
			reject_r   <= 1'b0;
		end else begin
			if (reg_wr && !cp_wr_ok && (reg_addr == `CDEA_OFF_CP07
				|| reg_addr == `CDEA_OFF_IO02))
				reject_r <= 1'b1;
			if (reg_wr && cp_wr_ok && reg_addr == `CDEA_OFF_CP07)
				cp07_r <= reg_wdata;
			else if (dis_pend_r && (st_r == st_idle || alert_go))
				cp07_r[`CDEA_B_IF_EN] <= 1'b0;
			if (reg_wr && cp_wr_ok && reg_addr == `CDEA_OFF_IO02)
				alert_en_r <= reg_wdata[`CDEA_B_ALERT_EN];
		end
	end

	// Disable request waits for the channel to go idle, else alert if enabled and feature present
	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por) begin
			dis_pend_r <= 1'b0;
			dis_cnt_r  <= 8'h00;
		end else if (reg_wr && cp_wr_ok && reg_addr == `CDEA_OFF_CP07
			&& reg_wdata[`CDEA_B_ALLOW_DIS]) begin
			dis_pend_r <= 1'b1;
			dis_cnt_r  <= 8'h00;
		end else if (dis_pend_r) begin
			if (st_r == st_idle || alert_go
				|| dis_cnt_r == 8'(`CDEA_DIS_TMO_CYC - 1))
				dis_pend_r <= 1'b0;
			dis_cnt_r <= dis_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por) begin
			st_r        <= st_idle;
			alert_cnt_r <= 8'h00;
		end else if (alert_go) begin
			st_r        <= st_alert;
			alert_cnt_r <= 8'h00;
		end else begin
			unique case (st_r)
				st_idle: begin
					if (host_if_en && tg.lvl[`CDEA_TAG_ADDR] && tg.rise[`CDEA_TAG_SEL])
						st_r <= st_init;
				end
				st_init: begin
					if (disc_ev || seq_done)
						st_r <= st_idle;
					else if (seq_next)
						st_r <= st_xfer;
				end
				st_xfer: begin
					if (disc_ev || cstop_ev || seq_done)
						st_r <= st_idle;
				end
				st_alert: begin
					alert_cnt_r <= alert_cnt_r + 8'h01;
					if (alert_cnt_r == 8'(`CDEA_ALERT_CYC - 1))
						st_r <= st_idle;
				end
			endcase
		end
	end

	assign op_in       = st_r == st_init || st_r == st_xfer;
	assign disc_in     = st_r == st_alert;
	assign chan_end_in = chan_end_r;

	// Flags: set wins over clear-on-read
	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por) begin
			disc_r  <= 1'b0;
			cstop_r <= 1'b0;
		end else begin
			if (st_r == st_init && disc_ev)
				disc_r <= 1'b1;
			else if (reg_rd && reg_addr == `CDEA_OFF_IN00)
				disc_r <= 1'b0;
			if ((st_r == st_xfer && disc_ev) || cstop_ev)
				cstop_r <= 1'b1;
			else if (reg_rd && reg_addr == `CDEA_OFF_IO02)
				cstop_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			init_ev_r  <= 1'b0;
			data_ev_r  <= 1'b0;
			chan_end_r <= 1'b0;
		end else begin
			init_ev_r  <= st_r == st_init && disc_ev;
			data_ev_r  <= (st_r == st_xfer && disc_ev) || cstop_ev;
			// Block or selector channel gets channel end instead
			chan_end_r <= cstop_ev && !cp07_r[`CDEA_B_BYTE_MUX];
		end
	end

	// Mode definition steers requests to one destination
	assign l3_init_ccu = init_ev_r && !sp07_r[`CDEA_B_ROUTE_SP];
	assign l3_data_ccu = data_ev_r && !sp07_r[`CDEA_B_ROUTE_SP];
	assign l3_init_sp  = init_ev_r && sp07_r[`CDEA_B_ROUTE_SP];
	assign l3_data_sp  = data_ev_r && sp07_r[`CDEA_B_ROUTE_SP];

	// Abandoning avoids any save/restore of routine state
	assign diag_busy = cpu_intr_busy || init_ev_r || data_ev_r;
	always_ff @(posedge core_clk) begin
		if (!resetn || soft_por || !chk_done_r) begin
			diag_idx_r <= 2'h0;
			diag_cnt_r <= 4'h0;
		end else if (diag_busy) begin
			if (diag_cnt_r != 4'h0) begin
				diag_cnt_r <= 4'h0;
				diag_idx_r <= diag_idx_r + 2'h1;
			end
		end else if (diag_cnt_r == 4'(`CDEA_DIAG_LEN - 1)) begin
			diag_cnt_r <= 4'h0;
			diag_idx_r <= diag_idx_r + 2'h1;
		end else begin
			diag_cnt_r <= diag_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CDEA_OFF_IN00: rdata_r <= {14'h0000, disc_r, 1'b0};
				`CDEA_OFF_IO02: rdata_r <= {8'h00, alert_en_r, 1'b0, cstop_r, 5'h00};
				`CDEA_OFF_CP07: rdata_r <= cp07_r;
				`CDEA_OFF_SP07: rdata_r <= {8'h00, sp07_r};
				`CDEA_OFF_SP4B: rdata_r <= {14'h0000, chk_pass_r, chk_done_r};
				`CDEA_OFF_SP4C: rdata_r <= {11'h000, sp4c_r};
				`CDEA_OFF_DIAG: rdata_r <= {9'h000, reject_r, diag_idx_r, diag_cnt_r};
				default:        rdata_r <= 16'h0000;
			endcase
		end
	end
	assign reg_rdata = rdata_r;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_init_disc_flag: assert property (st_r == st_init && disc_ev && !alert_go && !soft_por
		|=> disc_r && (l3_init_ccu || l3_init_sp))
		else $error("init disconnect not flagged");
	a_xfer_disc_flag: assert property (st_r == st_xfer && disc_ev && !alert_go && !soft_por
		|=> cstop_r && (l3_data_ccu || l3_data_sp) && !op_in)
		else $error("transfer disconnect not flagged");
	a_disc_detect: assert property (op_in && tg.lvl[`CDEA_TAG_ADDR] && tg.fall[`CDEA_TAG_SEL]
		&& !soft_por |=> !op_in ##1 !op_in || !host_if_en)
		else $error("adapter stayed on channel");
	a_alert_length: assert property ($fell(disc_in) && !$past(soft_por)
		|-> $past(alert_cnt_r) == 8'(`CDEA_ALERT_CYC - 1))
		else $error("alert length wrong");
	a_sp_alert_go: assert property (sp_alert && chk_done_r && st_r != st_alert && !soft_por
		|=> disc_in && !op_in)
		else $error("service alert not run");
	a_cp_alert_gate: assert property ($rose(disc_in) && !$past(sp_alert)
		|-> $past(alert_en_r && alert_feature_present && dis_pend_r))
		else $error("alert without enable");
	a_route_one: assert property (init_ev_r || data_ev_r
		|-> (l3_init_sp || l3_data_sp) == sp07_r[`CDEA_B_ROUTE_SP])
		else $error("interrupt misrouted");
	a_checkout_end: assert property ($rose(chk_done_r)
		|-> ioc_en && sp_conn_en && !host_if_en)
		else $error("bad state after checkout");
	a_checkout_read: assert property (reg_rd && reg_addr == `CDEA_OFF_SP4B
		|=> reg_rdata[1:0] == $past({chk_pass_r, chk_done_r}))
		else $error("checkout result wrong");
	a_diag_abandon: assert property (chk_done_r && diag_busy && diag_cnt_r != 4'h0 && !soft_por
		|=> diag_cnt_r == 4'h0 && diag_idx_r == $past(diag_idx_r) + 2'h1)
		else $error("routine not abandoned");
	a_nc_refuse: assert property (reg_wr && !cp_wr_ok && reg_addr == `CDEA_OFF_CP07 && !soft_por
		&& !dis_pend_r |=> $stable(cp07_r) && reject_r)
		else $error("command not refused");
	a_por_restart: assert property (soft_por |=> !chk_done_r && !host_if_en)
		else $error("reset did not restart");

	c_init_disc: cover property (st_r == st_init && disc_ev);
	c_chan_stop: cover property (cstop_ev ##1 chan_end_in);
	c_alert_run: cover property ($fell(disc_in));
	c_diag_skip: cover property (diag_busy && diag_cnt_r != 4'h0);
endmodule // cdea_top
`default_nettype wire

// *** hw/cdea_defines.svh ***
`ifndef CDEA_DEFINES_SVH
`define CDEA_DEFINES_SVH

`define CDEA_ADDR_W        8
`define CDEA_DATA_W        16

`define CDEA_OFF_IN00      8'h00
`define CDEA_OFF_IO02      8'h02
`define CDEA_OFF_CP07      8'h07
`define CDEA_OFF_SP07      8'h17
`define CDEA_OFF_DIAG      8'h20
`define CDEA_OFF_SP4B      8'h4B
`define CDEA_OFF_SP4C      8'h4C

`define CDEA_B_DISC        1
`define CDEA_B_CSTOP       5
`define CDEA_B_ALERT_EN    7
`define CDEA_B_IF_EN       0
`define CDEA_B_BYTE_MUX    1
`define CDEA_B_ALLOW_DIS   15
`define CDEA_B_CONCUR      0
`define CDEA_B_ROUTE_SP    1
`define CDEA_B_SVC_SEL     2
`define CDEA_B_SP_RESET    7
`define CDEA_B_WRAP_INT    0
`define CDEA_B_WRAP_EXT    1

`define CDEA_TAG_ADDR      0
`define CDEA_TAG_SEL       1
`define CDEA_TAG_CMD       2

`define CDEA_CLK_MHZ       125
`define CDEA_ALERT_NS      1000
`define CDEA_ALERT_CYC     ((`CDEA_ALERT_NS * `CDEA_CLK_MHZ) / 1000)
`define CDEA_DIS_TMO_NS    2000
`define CDEA_DIS_TMO_CYC   ((`CDEA_DIS_TMO_NS * `CDEA_CLK_MHZ) / 1000)
`define CDEA_CHK_CYC       64
`define CDEA_DIAG_LEN      16

`endif

// *** hw/cdea_pkg.sv ***
`default_nettype none
package cdea_pkg;
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_init  = 2'b01,
		st_xfer  = 2'b11,
		st_alert = 2'b10
	} cdea_state_t;
endpackage
`default_nettype wire

// *** hw/cdea_tag_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface cdea_tag_if;
	logic [2:0] raw;
	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;
	modport sync (input raw, output lvl, output rise, output fall);
	modport core (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

// *** hw/cdea_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module cdea_pin_sync (
	input  wire logic core_clk,
	input  wire logic resetn,
	cdea_tag_if.sync  tg
);
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_tag
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			logic rise_r;
			logic fall_r;
			always_ff @(posedge core_clk) begin
				if (!resetn) begin
					s1_r   <= 1'b0;
					s2_r   <= 1'b0;
					s3_r   <= 1'b0;
					lvl_r  <= 1'b0;
					rise_r <= 1'b0;
					fall_r <= 1'b0;
				end else begin
					s1_r   <= tg.raw[gi];
					s2_r   <= s1_r;
					s3_r   <= s2_r;
					// Change counts only once second and third stage agree
					if (s2_r == s3_r)
						lvl_r <= s3_r;
					rise_r <= (s2_r == s3_r) && s3_r && !lvl_r;
					fall_r <= (s2_r == s3_r) && !s3_r && lvl_r;
				end
			end
			assign tg.lvl[gi]  = lvl_r;
			assign tg.rise[gi] = rise_r;
			assign tg.fall[gi] = fall_r;
		end
	endgenerate
endmodule // cdea_pin_sync
`default_nettype wire

// *** test/cdea_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cdea_host_model (
	input  wire logic core_clk,
	output logic      address_out,
	output logic      select_out,
	output logic      command_out
);
	initial begin
		address_out = 1'b0;
		select_out  = 1'b0;
		command_out = 1'b0;
	end
	// Address first, select after a host-chosen gap
	task automatic select_on(input int gap);
		@(posedge core_clk) address_out <= 1'b1;
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk) select_out <= 1'b1;
	endtask
	// Address stays up so the drop reads as a disconnect
	task automatic hold_drop;
		@(posedge core_clk) select_out <= 1'b0;
	endtask
	task automatic chan_stop;
		@(posedge core_clk) command_out <= 1'b1;
	endtask
	task automatic release_all;
		@(posedge core_clk) begin
			select_out  <= 1'b0;
			command_out <= 1'b0;
		end
		@(posedge core_clk) address_out <= 1'b0;
	endtask
endmodule // cdea_host_model
`default_nettype wire

// *** test/cdea_top_tb.sv ***
`include "cdea_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module cdea_top_tb;
	logic        core_clk, resetn, reg_wr, reg_rd, seq_next, seq_done;
	logic        feat, sp_rst, sp_nohold, busy, op_in, disc_in, chan_end_in;
	logic        ext_wrap_en, ioc_en, sp_conn_en, host_if_en, svc_select;
	logic        i_ccu, d_ccu, i_sp, d_sp;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_val, v0;
	logic [15:0] cnt [6];
	wire         a_o, s_o, c_o;
	int          n_errors, comparisons;

	cdea_host_model u_host (.core_clk(core_clk), .address_out(a_o), .select_out(s_o),
		.command_out(c_o));
	cdea_top u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_address_out(a_o), .host_select_out(s_o), .host_command_out(c_o),
		.op_in(op_in), .disc_in(disc_in), .chan_end_in(chan_end_in),
		.ext_wrap_en(ext_wrap_en), .seq_next(seq_next), .seq_done(seq_done),
		.alert_feature_present(feat), .sp_reset_line(sp_rst), .sp_nohold_line(sp_nohold),
		.cpu_intr_busy(busy), .l3_init_ccu(i_ccu), .l3_data_ccu(d_ccu), .l3_init_sp(i_sp),
		.l3_data_sp(d_sp), .ioc_en(ioc_en), .sp_conn_en(sp_conn_en),
		.host_if_en(host_if_en), .svc_select(svc_select));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Interrupt and channel-end pulses are one cycle wide, so count them; disc_in count gives alert cycles
	always @(posedge core_clk) begin
		cnt[0] <= cnt[0] + {15'h0, i_ccu};
		cnt[1] <= cnt[1] + {15'h0, d_ccu};
		cnt[2] <= cnt[2] + {15'h0, i_sp};
		cnt[3] <= cnt[3] + {15'h0, d_sp};
		cnt[4] <= cnt[4] + {15'h0, chan_end_in};
		cnt[5] <= cnt[5] + {15'h0, disc_in};
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic clr;
		foreach (cnt[i]) cnt[i] = 16'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk) begin
			reg_addr  <= a;
			reg_wdata <= d;
			reg_wr    <= 1'b1;
		end
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge core_clk) begin
			reg_addr <= a;
			reg_rd   <= 1'b1;
		end
		@(posedge core_clk) reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
		chk(rd_val & m, e);
	endtask
	// Order: seq_next, seq_done, service reset, no-hold
	task automatic drive_in(input logic [3:0] v);
		@(posedge core_clk) {seq_next, seq_done, sp_rst, sp_nohold} <= v;
		@(posedge core_clk) {seq_next, seq_done, sp_rst, sp_nohold} <= 4'h0;
	endtask
	task automatic wait_op(input logic e);
		for (int i = 0; i < 30 && op_in !== e; i++) tick(1);
		chk({15'h0, op_in}, {15'h0, e});
	endtask
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		close_out();
	end

	initial begin
		{resetn, reg_wr, reg_rd, seq_next, seq_done, feat, sp_rst, sp_nohold, busy} = 9'h0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		clr();
		tick(10);
		chk({op_in, disc_in, ioc_en, host_if_en}, 4'h0);
		@(posedge core_clk) resetn <= 1'b1;
		tick(2);
		chk(ioc_en, 1'b0);
		// Program activity waits for checkout to finish
		tick(70);
		chk({ioc_en, sp_conn_en, host_if_en}, 3'b110);
		rdc(`CDEA_OFF_SP4B, 16'h0003, 16'h0003);
		rdc(8'h30, 16'hFFFF, 16'h0000);
		$display("test checkout done");
		wr(`CDEA_OFF_CP07, 16'h0001);
		for (int r = 0; r < 2; r++) begin
			wr(`CDEA_OFF_SP07, r ? 16'h0002 : 16'h0000);
			clr();
			u_host.select_on(r * 3);
			wait_op(1'b1);
			u_host.hold_drop();
			tick(8);
			chk(op_in, 1'b0);
			chk(cnt[0], r ? 16'h0 : 16'h1);
			chk(cnt[2], r ? 16'h1 : 16'h0);
			tick(20);
			rdc(`CDEA_OFF_IN00, 16'hFFFF, 16'h0002);
			rdc(`CDEA_OFF_IN00, 16'hFFFF, 16'h0000);
			u_host.release_all();
		end
		wr(`CDEA_OFF_SP07, 16'h0000);
		$display("test selection disconnect done");
		for (int m = 0; m < 3; m++) begin
			wr(`CDEA_OFF_CP07, (m == 2) ? 16'h0003 : 16'h0001);
			// Last pass also steers requests to the service side
			wr(`CDEA_OFF_SP07, (m == 2) ? 16'h0002 : 16'h0000);
			clr();
			u_host.select_on(0);
			wait_op(1'b1);
			drive_in(4'h8);
			tick(3);
			if (m == 0) u_host.hold_drop();
			else u_host.chan_stop();
			tick(8);
			chk(op_in, 1'b0);
			chk(cnt[1], (m == 2) ? 16'h0 : 16'h1);
			chk(cnt[3], (m == 2) ? 16'h1 : 16'h0);
			chk(cnt[4], (m == 1) ? 16'h1 : 16'h0);
			rdc(`CDEA_OFF_IO02, 16'hFFFF, 16'h0020);
			u_host.release_all();
			tick(8);
		end
		clr();
		u_host.select_on(1);
		wait_op(1'b1);
		drive_in(4'h4);
		tick(3);
		chk(op_in, 1'b0);
		u_host.release_all();
		tick(8);
		chk(cnt[0] + cnt[1] + cnt[2] + cnt[3], 16'h0);
		rdc(`CDEA_OFF_IN00, 16'hFFFF, 16'h0000);
		$display("test transfer disconnect done");
		clr();
		drive_in(4'h2);
		tick(5);
		chk(cnt[5], 16'h0);
		drive_in(4'h3);
		tick(130);
		chk(cnt[5], 16'h007D);
		wr(`CDEA_OFF_IO02, 16'h0080);
		rdc(`CDEA_OFF_IO02, 16'h0080, 16'h0080);
		for (int f = 0; f < 2; f++) begin
			@(posedge core_clk) feat <= f[0];
			wr(`CDEA_OFF_CP07, 16'h0001);
			u_host.select_on(0);
			wait_op(1'b1);
			clr();
			wr(`CDEA_OFF_CP07, 16'h8001);
			tick(450);
			chk(cnt[5], f ? 16'h007D : 16'h0000);
			// Without the feature the disable request just lapses
			chk(host_if_en, f ? 1'b0 : 1'b1);
			u_host.release_all();
			tick(8);
		end
		$display("test error alert done");
		wr(`CDEA_OFF_SP07, 16'h0004);
		tick(2);
		chk(svc_select, 1'b1);
		wr(`CDEA_OFF_CP07, 16'h0001);
		tick(2);
		chk(host_if_en, 1'b0);
		rdc(`CDEA_OFF_DIAG, 16'h0040, 16'h0040);
		wr(`CDEA_OFF_SP07, 16'h0005);
		wr(`CDEA_OFF_CP07, 16'h0001);
		tick(2);
		chk(host_if_en, 1'b1);
		// Internal wrap plays the host: address, select, then select drop
		wr(`CDEA_OFF_SP4C, 16'h0005);
		wr(`CDEA_OFF_SP4C, 16'h000D);
		wait_op(1'b1);
		wr(`CDEA_OFF_SP4C, 16'h0005);
		wait_op(1'b0);
		rdc(`CDEA_OFF_IN00, 16'hFFFF, 16'h0002);
		wr(`CDEA_OFF_SP4C, 16'h0002);
		tick(2);
		chk(ext_wrap_en, 1'b1);
		rdc(`CDEA_OFF_SP4C, 16'hFFFF, 16'h0002);
		@(posedge core_clk) busy <= 1'b1;
		tick(3);
		rdc(`CDEA_OFF_DIAG, 16'h004F, 16'h0040);
		v0 = rd_val;
		tick(10);
		rdc(`CDEA_OFF_DIAG, 16'h003F, v0 & 16'h003F);
		@(posedge core_clk) busy <= 1'b0;
		$display("test service modes done");
		wr(`CDEA_OFF_SP07, 16'h0080);
		tick(2);
		chk({ioc_en, host_if_en}, 2'b00);
		tick(70);
		chk({ioc_en, sp_conn_en, svc_select}, 3'b110);
		rdc(`CDEA_OFF_DIAG, 16'h0040, 16'h0000);
		rdc(`CDEA_OFF_SP4B, 16'h0003, 16'h0003);
		$display("test soft reset done");
		close_out();
	end
endmodule // cdea_top_tb
`default_nettype wire
